// ==== rssu_sync_unit.sv ====
`timescale 1ns/100ps
// Behaviour
// - No deferral: writes apply at once
// - Defer bit 0 holds target until start
// - Defer bit 1 holds velocity until start
// - Defer bit 2 holds ramp mode until start
// - Defer bit 3 holds step_scaling_factor until start
// - Defer bit 4 loads shadow set on start
// - Deferral field bits 4:0, independent
// - Start follows trigger after delay cycles
// - Pin trigger delayed like internal ones
// - Bypass bit: pin trigger starts immediately
// - Pin triggers ignored during countdown unless bypass bit set
// - Polarity clear: pin active low
// - Polarity set: pin active high
// - Output pulse lasts extension plus one
// - Host data applied at datagram end
// - Target deferred and no new target: no ramp
// - Trigger field bits 8:5, zero disables
// - Source bits 1-3 pick internal events
// - Triggers are rising transitions only
module rssu_sync_unit #(
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic [6:0] host_addr,
  input wire logic [DATA_W-1:0] host_wdata,
  input wire logic [6:0] host_raddr,
  output logic [DATA_W-1:0] host_rdata,
  input wire logic target_reached_event,
  input wire logic velocity_reached_event,
  input wire logic compare_hit_event,
  input wire logic start_pin_in,
  output logic start_pin_out,
  output logic start_pin_oe,
  output logic [DATA_W-1:0] target_position,
  output logic [DATA_W-1:0] max_velocity,
  output logic [DATA_W-1:0] ramp_profile_select,
  output logic [DATA_W-1:0] step_scaling_factor,
  output logic shadow_load,
  output logic ramp_start,
  output logic internal_start
);
  import rssu_pkg::*;

  // Config fields reach bit 10
  if (DATA_W < 11) begin : g_width_check
    $error("DATA_W too small");
  end

  function automatic logic is_wr(input logic we, input logic [6:0] a, input logic [6:0] ref_a);
    is_wr = we && (a == ref_a);
  endfunction : is_wr

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [DATA_W-1:0] cfg_reg, cfg_next;
  logic [DATA_W-1:0] ext_reg, ext_next;
  logic [DATA_W-1:0] dly_reg, dly_next;
  logic [DATA_W-1:0] rdata_next;

  // host_wr is the end-of-datagram strobe; nothing moves mid-frame
  always_comb begin
    cfg_next = cfg_reg;
    ext_next = ext_reg;
    dly_next = dly_reg;
    if (is_wr(host_wr, host_addr, RSSU_ADDR_START_CONFIG)) cfg_next = host_wdata;
    if (is_wr(host_wr, host_addr, RSSU_ADDR_PULSE_EXT)) ext_next = host_wdata;
    if (is_wr(host_wr, host_addr, RSSU_ADDR_TRIG_DELAY)) dly_next = host_wdata;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= DATA_W'(RSSU_RST_START_CONFIG);
      ext_reg <= DATA_W'(RSSU_RST_PULSE_EXT);
      dly_reg <= DATA_W'(RSSU_RST_TRIG_DELAY);
    end else begin
      cfg_reg <= cfg_next;
      ext_reg <= ext_next;
      dly_reg <= dly_next;
    end
  end

  logic [4:0] defer_en;
  logic [3:0] trig_src;
  logic pol_high;
  logic bypass;
  assign defer_en = cfg_reg[RSSU_DEFER_SHADOW_BIT:RSSU_DEFER_TARGET_BIT];
  assign trig_src = cfg_reg[RSSU_TRIG_CMP_BIT:RSSU_TRIG_LSB];
  assign pol_high = cfg_reg[RSSU_POL_BIT];
  assign bypass = cfg_reg[RSSU_BYPASS_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Trigger detection
  logic tgt_d_reg, vel_d_reg, cmp_d_reg, pin_d_reg;
  logic pin_active, pin_prev_active;
  logic int_trig, ext_trig;

  // Active-level pin after polarity
  assign pin_active = pol_high ? start_pin_in : ~start_pin_in;
  // Raw pin history, so a polarity change alone is no edge
  assign pin_prev_active = pol_high ? pin_d_reg : ~pin_d_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgt_d_reg <= 1'b0;
      vel_d_reg <= 1'b0;
      cmp_d_reg <= 1'b0;
      pin_d_reg <= 1'b1;
    end else begin
      tgt_d_reg <= target_reached_event;
      vel_d_reg <= velocity_reached_event;
      cmp_d_reg <= compare_hit_event;
      pin_d_reg <= start_pin_in;
    end
  end

  // Edges, not levels, so a held event fires once
  assign int_trig = (trig_src[1] && target_reached_event && !tgt_d_reg)
                 || (trig_src[2] && velocity_reached_event && !vel_d_reg)
                 || (trig_src[3] && compare_hit_event && !cmp_d_reg);
  // Own drive still on the pin right after a direction change is no trigger
  assign ext_trig = trig_src[0] && !start_pin_oe && pin_active && !pin_prev_active;

  ////////////////////////////////////////////////////////////////////////
  // Start delay
  logic dly_busy, dly_expire;
  logic dly_load, dly_clear;
  logic start_now;
  logic any_trig;

  assign any_trig = int_trig || ext_trig;
  // Countdown running blocks all new triggers except a pin trigger with bypass set
  assign dly_load = any_trig && !dly_busy && (dly_reg != '0) && !(ext_trig && bypass);
  assign dly_clear = ext_trig && bypass;

  always_comb begin
    start_now = 1'b0;
    if (trig_src == 4'h0) begin
      start_now = 1'b0;
    end else if (ext_trig && bypass) begin
      start_now = 1'b1;
    end else if (dly_expire) begin
      start_now = 1'b1;
    end else if (any_trig && !dly_busy && dly_reg == '0) begin
      start_now = 1'b1;
    end
  end

  rssu_counter #(.WIDTH(DATA_W)) u_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(dly_load),
    .load_value(dly_reg),
    .clear(dly_clear),
    .busy(dly_busy),
    .expire(dly_expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // Deferred parameter updates
  logic [DATA_W-1:0] tgt_reg, tgt_next, tgt_pend_reg, tgt_pend_next;
  logic [DATA_W-1:0] vel_reg, vel_next, vel_pend_reg, vel_pend_next;
  logic [DATA_W-1:0] mode_reg, mode_next, mode_pend_reg, mode_pend_next;
  logic [DATA_W-1:0] gear_reg, gear_next, gear_pend_reg, gear_pend_next;
  logic [3:0] pend_reg, pend_next;
  logic shadow_next, ramp_next, start_next;

  always_comb begin
    tgt_next = tgt_reg;
    vel_next = vel_reg;
    mode_next = mode_reg;
    gear_next = gear_reg;
    tgt_pend_next = tgt_pend_reg;
    vel_pend_next = vel_pend_reg;
    mode_pend_next = mode_pend_reg;
    gear_pend_next = gear_pend_reg;
    pend_next = pend_reg;
    ramp_next = 1'b0;
    shadow_next = start_now && defer_en[RSSU_DEFER_SHADOW_BIT];
    start_next = start_now;
    // Start applies pending values first; same-cycle write lands after
    if (start_now) begin
      if (pend_reg[0]) tgt_next = tgt_pend_reg;
      if (pend_reg[1]) vel_next = vel_pend_reg;
      if (pend_reg[2]) mode_next = mode_pend_reg;
      if (pend_reg[3]) gear_next = gear_pend_reg;
      // Deferred target with nothing new: no ramp
      ramp_next = !defer_en[RSSU_DEFER_TARGET_BIT] || pend_reg[0];
      pend_next = 4'h0;
    end
    if (is_wr(host_wr, host_addr, RSSU_ADDR_TARGET_POS)) begin
      if (defer_en[RSSU_DEFER_TARGET_BIT]) begin
        tgt_pend_next = host_wdata;
        pend_next[0] = 1'b1;
      end else begin
        tgt_next = host_wdata;
      end
    end
    if (is_wr(host_wr, host_addr, RSSU_ADDR_MAX_VEL)) begin
      if (defer_en[RSSU_DEFER_VEL_BIT]) begin
        vel_pend_next = host_wdata;
        pend_next[1] = 1'b1;
      end else begin
        vel_next = host_wdata;
      end
    end
    if (is_wr(host_wr, host_addr, RSSU_ADDR_RAMP_PROFILE)) begin
      if (defer_en[RSSU_DEFER_MODE_BIT]) begin
        mode_pend_next = host_wdata;
        pend_next[2] = 1'b1;
      end else begin
        mode_next = host_wdata;
      end
    end
    if (is_wr(host_wr, host_addr, RSSU_ADDR_STEP_SCALE)) begin
      if (defer_en[RSSU_DEFER_GEAR_BIT]) begin
        gear_pend_next = host_wdata;
        pend_next[3] = 1'b1;
      end else begin
        gear_next = host_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgt_reg <= DATA_W'(RSSU_RST_DATA);
      vel_reg <= DATA_W'(RSSU_RST_DATA);
      mode_reg <= DATA_W'(RSSU_RST_DATA);
      gear_reg <= DATA_W'(RSSU_RST_DATA);
      tgt_pend_reg <= DATA_W'(RSSU_RST_DATA);
      vel_pend_reg <= DATA_W'(RSSU_RST_DATA);
      mode_pend_reg <= DATA_W'(RSSU_RST_DATA);
      gear_pend_reg <= DATA_W'(RSSU_RST_DATA);
      pend_reg <= 4'h0;
      shadow_load <= 1'b0;
      ramp_start <= 1'b0;
      internal_start <= 1'b0;
    end else begin
      tgt_reg <= tgt_next;
      vel_reg <= vel_next;
      mode_reg <= mode_next;
      gear_reg <= gear_next;
      tgt_pend_reg <= tgt_pend_next;
      vel_pend_reg <= vel_pend_next;
      mode_pend_reg <= mode_pend_next;
      gear_pend_reg <= gear_pend_next;
      pend_reg <= pend_next;
      shadow_load <= shadow_next;
      ramp_start <= ramp_next;
      internal_start <= start_next;
    end
  end

  assign target_position = tgt_reg;
  assign max_velocity = vel_reg;
  assign ramp_profile_select = mode_reg;
  assign step_scaling_factor = gear_reg;

  ////////////////////////////////////////////////////////////////////////
  // Start pin output pulse
  logic [DATA_W-1:0] pulse_cnt_reg, pulse_cnt_next;
  logic pulse_on_reg, pulse_on_next;
  logic pin_out_next, pin_oe_next;

  always_comb begin
    pulse_cnt_next = pulse_cnt_reg;
    pulse_on_next = pulse_on_reg;
    if (start_now && !trig_src[0]) begin
      pulse_on_next = 1'b1;
      pulse_cnt_next = ext_reg;
    end else if (pulse_on_reg) begin
      if (pulse_cnt_reg == '0) begin
        pulse_on_next = 1'b0;
      end else begin
        pulse_cnt_next = pulse_cnt_reg - 1'b1;
      end
    end
    pin_oe_next = !trig_src[0];
    pin_out_next = pulse_on_next ? pol_high : ~pol_high;
    rdata_next = '0;
    case (host_raddr)
      RSSU_ADDR_START_CONFIG: rdata_next = cfg_reg;
      RSSU_ADDR_PULSE_EXT: rdata_next = ext_reg;
      RSSU_ADDR_TRIG_DELAY: rdata_next = dly_reg;
      RSSU_ADDR_TARGET_POS: rdata_next = tgt_reg;
      RSSU_ADDR_MAX_VEL: rdata_next = vel_reg;
      RSSU_ADDR_RAMP_PROFILE: rdata_next = mode_reg;
      RSSU_ADDR_STEP_SCALE: rdata_next = gear_reg;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_cnt_reg <= '0;
      pulse_on_reg <= 1'b0;
      start_pin_out <= 1'b1;
      start_pin_oe <= 1'b0;
      host_rdata <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
      pulse_on_reg <= pulse_on_next;
      start_pin_out <= pin_out_next;
      start_pin_oe <= pin_oe_next;
      host_rdata <= rdata_next;
    end
  end
endmodule : rssu_sync_unit

// ==== rssu_pkg.sv ====
package rssu_pkg;
  // Register addresses
  localparam logic [6:0] RSSU_ADDR_START_CONFIG = 7'h02;
  localparam logic [6:0] RSSU_ADDR_PULSE_EXT = 7'h11;
  localparam logic [6:0] RSSU_ADDR_TRIG_DELAY = 7'h13;
  localparam logic [6:0] RSSU_ADDR_TARGET_POS = 7'h37;
  localparam logic [6:0] RSSU_ADDR_MAX_VEL = 7'h24;
  localparam logic [6:0] RSSU_ADDR_RAMP_PROFILE = 7'h20;
  localparam logic [6:0] RSSU_ADDR_STEP_SCALE = 7'h12;
  // Start configuration fields
  localparam int RSSU_DEFER_TARGET_BIT = 0;
  localparam int RSSU_DEFER_VEL_BIT = 1;
  localparam int RSSU_DEFER_MODE_BIT = 2;
  localparam int RSSU_DEFER_GEAR_BIT = 3;
  localparam int RSSU_DEFER_SHADOW_BIT = 4;
  localparam int RSSU_TRIG_LSB = 5;
  localparam int RSSU_TRIG_EXT_BIT = 5;
  localparam int RSSU_TRIG_TGT_BIT = 6;
  localparam int RSSU_TRIG_VEL_BIT = 7;
  localparam int RSSU_TRIG_CMP_BIT = 8;
  localparam int RSSU_POL_BIT = 9;
  localparam int RSSU_BYPASS_BIT = 10;
  // Reset values
  localparam logic [31:0] RSSU_RST_START_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RSSU_RST_PULSE_EXT = 32'h0000_0000;
  localparam logic [31:0] RSSU_RST_TRIG_DELAY = 32'h0000_0000;
  localparam logic [31:0] RSSU_RST_DATA = 32'h0000_0000;
endpackage : rssu_pkg

// ==== rssu_counter.sv ====
`timescale 1ns/100ps
// Loadable down counter; busy while nonzero
module rssu_counter #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic clear,
  output logic busy,
  output logic expire
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic expire_next;

  always_comb begin
    cnt_next = cnt_reg;
    expire_next = 1'b0;
    if (clear) begin
      cnt_next = '0;
    end else if (load) begin
      cnt_next = load_value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
      expire_next = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign expire = expire_next;
endmodule : rssu_counter

// ==== rssu_sync_unit_sva.sv ====
`timescale 1ns/100ps
module rssu_sync_unit_sva
  import rssu_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic [6:0] host_addr,
  input wire logic [DATA_W-1:0] host_wdata,
  input wire logic target_reached_event,
  input wire logic start_pin_out,
  input wire logic start_pin_oe,
  input wire logic [DATA_W-1:0] target_position,
  input wire logic [DATA_W-1:0] max_velocity,
  input wire logic [DATA_W-1:0] ramp_profile_select,
  input wire logic [DATA_W-1:0] step_scaling_factor,
  input wire logic shadow_load,
  input wire logic ramp_start,
  input wire logic internal_start
);
  logic [DATA_W-1:0] cfg_reg, cfg_next, ext_reg, ext_next, dly_reg, dly_next;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the config registers, as seen at the write port
  always_comb begin
    cfg_next = cfg_reg;
    ext_next = ext_reg;
    dly_next = dly_reg;
    if (host_wr && host_addr == RSSU_ADDR_START_CONFIG) cfg_next = host_wdata;
    if (host_wr && host_addr == RSSU_ADDR_PULSE_EXT) ext_next = host_wdata;
    if (host_wr && host_addr == RSSU_ADDR_TRIG_DELAY) dly_next = host_wdata;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
      ext_reg <= '0;
      dly_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      ext_reg <= ext_next;
      dly_reg <= dly_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_ONE_CYCLE: assert property (internal_start |=> !internal_start)
    else $error("start pulse longer than one cycle");
  AST_SHADOW: assert property (shadow_load |-> internal_start && $past(cfg_reg[4]))
    else $error("shadow load outside an enabled start");
  AST_RAMP: assert property (ramp_start |-> internal_start)
    else $error("ramp start without start pulse");
  AST_NO_SRC: assert property (cfg_reg[8:5] == 4'h0 && $past(cfg_reg[8:5]) == 4'h0 |-> !internal_start)
    else $error("start with no trigger source");
  AST_DIRECT: assert property (host_wr && host_addr == RSSU_ADDR_TARGET_POS && !cfg_reg[0]
    |=> target_position == $past(host_wdata))
    else $error("undeferred target not applied");
  AST_HOLD_TGT: assert property ($changed(target_position) && $past(cfg_reg[0]) |-> internal_start)
    else $error("deferred target changed without start");
  AST_HOLD_VEL: assert property ($changed(max_velocity) && $past(cfg_reg[1]) |-> internal_start)
    else $error("deferred velocity changed without start");
  AST_HOLD_MODE: assert property (($changed(ramp_profile_select) && $past(cfg_reg[2]))
    || ($changed(step_scaling_factor) && $past(cfg_reg[3])) |-> internal_start)
    else $error("deferred mode or gear changed without start");
  AST_DELAY0: assert property ($rose(target_reached_event) && cfg_reg[6] && dly_reg == '0
    |=> internal_start)
    else $error("zero delay start late");
  AST_PULSE1: assert property (internal_start && start_pin_oe && ext_reg == '0
    |-> start_pin_out == cfg_reg[9] ##1 start_pin_out != cfg_reg[9])
    else $error("single pin pulse wrong");
  AST_PULSE4: assert property (internal_start && start_pin_oe && ext_reg == 32'h3
    |-> (start_pin_out == cfg_reg[9]) [*4] ##1 start_pin_out != cfg_reg[9])
    else $error("extended pin pulse wrong");
  AST_OE: assert property (!$past(rst) && cfg_reg[5] == $past(cfg_reg[5]) |-> start_pin_oe == !cfg_reg[5])
    else $error("pin direction wrong");
  COV_START: cover property (internal_start);
  COV_SHADOW: cover property (shadow_load);
  COV_RAMP: cover property (ramp_start);
endmodule : rssu_sync_unit_sva

bind rssu_sync_unit rssu_sync_unit_sva #(.DATA_W(DATA_W)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
  .target_reached_event(target_reached_event), .start_pin_out(start_pin_out), .start_pin_oe(start_pin_oe),
  .target_position(target_position), .max_velocity(max_velocity), .ramp_profile_select(ramp_profile_select),
  .step_scaling_factor(step_scaling_factor), .shadow_load(shadow_load), .ramp_start(ramp_start),
  .internal_start(internal_start)
);

// ==== rssu_pin_partner.sv ====
`timescale 1ns/100ps
module rssu_pin_partner (
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic pol,
  input wire logic start_pin_oe,
  input wire logic start_pin_out,
  output logic start_pin_in,
  output int pulse_len
);
  int hold_cnt = 0;
  int run = 0;
  // Holds the trigger a few cycles, then returns to idle
  always @(posedge clk_sys) begin
    if (fire) hold_cnt <= 3;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
    if (start_pin_oe && start_pin_out == pol) run <= run + 1;
    else if (run > 0) begin
      pulse_len <= run;
      run <= 0;
    end
  end
  // Released pin rests inactive, as a pull resistor would hold it
  assign start_pin_in = start_pin_oe ? start_pin_out : ((hold_cnt > 0) ? pol : !pol);
endmodule : rssu_pin_partner

// ==== rssu_sync_unit_test.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module rssu_sync_unit_test;
  import rssu_pkg::*;
  logic clk_sys = 0, rst = 1, host_wr = 0, fire = 0, pol = 0;
  logic [6:0] host_addr = '0, host_raddr = '0;
  logic [31:0] host_wdata = '0, host_rdata, target_position, max_velocity, ramp_profile_select, step_scaling_factor;
  logic [2:0] ev = '0;
  logic start_pin_in, start_pin_out, start_pin_oe, shadow_load, ramp_start, internal_start;
  int bad_count = 0, checked = 0, starts = 0, ramps = 0, shadows = 0, pulse_len, n, m, k;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    starts += (internal_start === 1'b1);
    ramps += (ramp_start === 1'b1);
    shadows += (shadow_load === 1'b1);
  end
  rssu_sync_unit dut (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_raddr(host_raddr), .host_rdata(host_rdata), .target_reached_event(ev[0]),
    .velocity_reached_event(ev[1]), .compare_hit_event(ev[2]), .start_pin_in(start_pin_in),
    .start_pin_out(start_pin_out), .start_pin_oe(start_pin_oe), .target_position(target_position),
    .max_velocity(max_velocity), .ramp_profile_select(ramp_profile_select),
    .step_scaling_factor(step_scaling_factor), .shadow_load(shadow_load), .ramp_start(ramp_start),
    .internal_start(internal_start));
  rssu_pin_partner u_far (.clk_sys(clk_sys), .fire(fire), .pol(pol), .start_pin_oe(start_pin_oe),
    .start_pin_out(start_pin_out), .start_pin_in(start_pin_in), .pulse_len(pulse_len));
  ////////////////////////////////////////////////////////////////////////////
  task wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk_sys);
    host_wr = 1'b0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [31:0] e);
    @(negedge clk_sys);
    host_raddr = a;
    @(negedge clk_sys);
    `CHK("rdata", e, host_rdata)
  endtask : rd
  // Pass through an all-off config so a polarity swap never looks like an edge
  task cfg(input logic [31:0] c);
    wr(RSSU_ADDR_START_CONFIG, 32'h0);
    pol = c[9];
    wr(RSSU_ADDR_START_CONFIG, c);
  endtask : cfg
  // Source 0-2 are events, 3 is the pin; cycles until start land in c
  task trig(input int i, output int c);
    @(negedge clk_sys);
    if (i < 3) ev[i] = 1'b1;
    else fire = 1'b1;
    c = 0;
    while (c < 100 && internal_start !== 1'b1) begin
      @(negedge clk_sys);
      fire = 1'b0;
      c++;
    end
    repeat (6) @(negedge clk_sys);
    ev = 3'h0;
  endtask : trig
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    rd(RSSU_ADDR_START_CONFIG, 32'h0);
    rd(RSSU_ADDR_TRIG_DELAY, 32'h0);
    wr(RSSU_ADDR_START_CONFIG, 32'h41f);
    rd(RSSU_ADDR_START_CONFIG, 32'h41f);
    wr(RSSU_ADDR_PULSE_EXT, 32'h3);
    rd(RSSU_ADDR_PULSE_EXT, 32'h3);
    rd(7'h7f, 32'h0);
    $display("registers done");
    cfg(32'h0);
    wr(RSSU_ADDR_TARGET_POS, 32'h1111);
    `CHK("tgt", 32'h1111, target_position)
    wr(RSSU_ADDR_MAX_VEL, 32'h2222);
    `CHK("vel", 32'h2222, max_velocity)
    cfg(32'h5f);
    wr(RSSU_ADDR_TARGET_POS, 32'ha1);
    wr(RSSU_ADDR_TARGET_POS, 32'ha2);
    wr(RSSU_ADDR_MAX_VEL, 32'hb1);
    wr(RSSU_ADDR_RAMP_PROFILE, 32'h5);
    wr(RSSU_ADDR_STEP_SCALE, 32'hd1);
    `CHK("tgt held", 32'h1111, target_position)
    `CHK("vel held", 32'h2222, max_velocity)
    {starts, ramps, shadows} = 0;
    trig(0, n);
    `CHK("delay0", 1, n)
    `CHK("tgt", 32'ha2, target_position)
    `CHK("vel", 32'hb1, max_velocity)
    `CHK("mode", 32'h5, ramp_profile_select)
    `CHK("gear", 32'hd1, step_scaling_factor)
    trig(0, n);
    `CHK("ramps", 1, ramps)
    `CHK("shadows", 2, shadows)
    $display("deferral done");
    for (int i = 0; i < 3; i++) begin
      cfg(32'h40 << i);
      starts = 0;
      trig(i, n);
      `CHK("event", 1, n)
      `CHK("one start", 1, starts)
    end
    cfg(32'h0);
    starts = 0;
    trig(1, n);
    `CHK("no source", 0, starts)
    wr(RSSU_ADDR_TRIG_DELAY, 32'h5);
    cfg(32'h100);
    trig(2, n);
    `CHK("delay5", 6, n)
    cfg(32'h20);
    trig(3, m);
    wr(RSSU_ADDR_TRIG_DELAY, 32'h0);
    trig(3, n);
    `CHK("pin delay", 5, m - n)
    cfg(32'h220);
    trig(3, k);
    `CHK("pin high", n, k)
    $display("triggers done");
    wr(RSSU_ADDR_TRIG_DELAY, 32'h14);
    cfg(32'h720);
    starts = 0;
    @(negedge clk_sys) ev[2] = 1'b1;
    repeat (5) @(negedge clk_sys);
    trig(3, k);
    `CHK("bypass", n, k)
    repeat (40) @(negedge clk_sys);
    `CHK("cut short", 1, starts)
    cfg(32'h320);
    starts = 0;
    @(negedge clk_sys) ev[2] = 1'b1;
    repeat (5) @(negedge clk_sys);
    trig(3, k);
    `CHK("ignored", 15, k)
    repeat (40) @(negedge clk_sys);
    `CHK("single", 1, starts)
    $display("priority done");
    wr(RSSU_ADDR_TRIG_DELAY, 32'h0);
    cfg(32'h240);
    trig(0, n);
    `CHK("pulse4", 4, pulse_len)
    wr(RSSU_ADDR_PULSE_EXT, 32'h0);
    cfg(32'h40);
    trig(0, n);
    `CHK("pulse1", 1, pulse_len)
    $display("pin output done");
    end_of_test();
  end
endmodule : rssu_sync_unit_test
